/* design/exec_pkg.sv */
// constants and types shared by the instruction execution slice
// assumes a 16-bit instruction word and a 12-bit data address space
package exec_pkg;

   // ***********************************
   // opcode fields
   // ***********************************
   localparam int          OPC_MSB       = 15;
   localparam int          OPC_LSB       = 10;
   localparam int          DEST_BIT      = 9;
   localparam int          ACCESS_BIT    = 8;
   localparam logic [5:0]  OPC_INC_SNZ   = 6'h12;   // 0100 10da
   localparam logic [5:0]  OPC_SWAP      = 6'h0E;   // 0011 10da
   localparam logic [5:0]  OPC_SUB_BRW   = 6'h16;   // 0101 10da
   localparam logic [15:0] INSTR_POP     = 16'h0006;
   localparam logic [15:0] INSTR_PUSH    = 16'h0005;

   // ***********************************
   // addressing
   // ***********************************
   localparam logic [7:0]  INDEX_LIMIT   = 8'h5F;   // offsets at or below use pointer
   localparam logic [7:0]  ACCESS_SPLIT  = 8'h80;   // upper half maps to top page
   localparam logic [3:0]  ACCESS_HIGH   = 4'hF;
   localparam logic [3:0]  ACCESS_LOW    = 4'h0;

   // ***********************************
   // status bits and stack
   // ***********************************
   localparam int          ST_C          = 0;
   localparam int          ST_DC         = 1;
   localparam int          ST_Z          = 2;
   localparam int          ST_OV         = 3;
   localparam int          ST_N          = 4;
   localparam int          STATUS_W      = 5;
   localparam int          PC_STEP       = 2;
   localparam int          STACK_DEPTH   = 31;

   typedef enum logic [1:0]
   {
      ST_IDLE  = 2'b00,
      ST_EXEC  = 2'b01,
      ST_SKIP1 = 2'b11,
      ST_SKIP2 = 2'b10
   } state_e;

   typedef enum logic [1:0]
   {
      OP_INC  = 2'b00,
      OP_SWAP = 2'b01,
      OP_SUB  = 2'b10,
      OP_NONE = 2'b11
   } alu_op_e;

endpackage

/* design/byte_alu.sv */
// byte arithmetic for increment, nibble exchange and subtract with borrow
// assumes operands stable through the execute cycle; purely combinational
`timescale 1ns/1ps
`default_nettype none
module byte_alu
   import exec_pkg::*;
(
   input  wire alu_op_e              i_op,
   input  wire logic [7:0]           i_fdata,
   input  wire logic [7:0]           i_wreg,
   input  wire logic                 i_carry,
   output logic      [7:0]           o_result,
   output logic      [STATUS_W-1:0]  o_flags,
   output logic                      o_nonzero
);

   logic [8:0] diff;
   logic [4:0] low_diff;

   // ***********************************
   // datapath
   // ***********************************
   // subtraction as f + ~w + c, so carry out means no borrow
   always_comb
   begin
      diff     = {1'b0, i_fdata} + {1'b0, ~i_wreg} + {8'h00, i_carry};
      low_diff = {1'b0, i_fdata[3:0]} + {1'b0, ~i_wreg[3:0]} + {4'h0, i_carry};
      case (i_op)
         OP_INC:  o_result = i_fdata + 8'h01;
         OP_SWAP: o_result = {i_fdata[3:0], i_fdata[7:4]};
         OP_SUB:  o_result = diff[7:0];
         default: o_result = i_fdata;
      endcase
      o_flags         = '0;
      o_flags[ST_C]   = diff[8];
      o_flags[ST_DC]  = low_diff[4];
      o_flags[ST_Z]   = (diff[7:0] == 8'h00);
      o_flags[ST_OV]  = (i_fdata[7] != i_wreg[7]) && (diff[7] != i_fdata[7]);
      o_flags[ST_N]   = diff[7];
      o_nonzero       = (o_result != 8'h00);
   end

endmodule
`default_nettype wire

/* design/exec_slice.sv */
// execution slice for increment-skip, nibble swap, subtract with borrow,
// and return stack pop and push
// assumes asynchronous file read: i_file_rdata follows o_file_addr in the same cycle,
// and the fetch stage holds off new instructions while o_busy is high
//
// Function
// - increment file byte, write destination, skip next instruction when result nonzero
// - exchange nibbles of file byte into destination, flags untouched
// - destination bit zero writes working register, one writes file register
// - extended set, access bit zero, operand up to 5Fh offsets the index pointer
// - subtract working register and inverted carry from file byte, update N OV C DC Z
// - carry one means no borrow; carry out cleared on underflow
// - pop discards top of return stack in one cycle, no flags
// - push stores program counter plus two on return stack in one cycle
// - access bit zero uses access bank, one uses bank select register
// - a taken skip replaces the fetched next instruction with a no-operation
`timescale 1ns/1ps
`default_nettype none
module exec_slice
   import exec_pkg::*;
#(
   parameter int PC_W  = 21,
   parameter int DEPTH = STACK_DEPTH
)
(
   input  wire logic                 i_clk,
   input  wire logic                 i_srst,
   input  wire logic                 i_instr_valid,
   input  wire logic [15:0]          i_instr,
   input  wire logic [PC_W-1:0]      i_pc,
   input  wire logic [7:0]           i_wreg,
   input  wire logic [3:0]           i_bank_select_register,
   input  wire logic [11:0]          i_index_ptr,
   input  wire logic                 i_ext_en,
   input  wire logic [STATUS_W-1:0]  i_status,
   input  wire logic [7:0]           i_file_rdata,
   input  wire logic                 i_next_two_word,
   output logic                      o_busy,
   output logic      [11:0]          o_file_addr,
   output logic                      o_file_we,
   output logic      [7:0]           o_file_wdata,
   output logic                      o_wreg_we,
   output logic      [7:0]           o_wreg_wdata,
   output logic                      o_status_we,
   output logic      [STATUS_W-1:0]  o_status,
   output logic                      o_flush,
   output logic      [PC_W-1:0]      o_return_stack_top,
   output logic      [4:0]           o_stack_ptr
);

   // ***********************************
   // helpers
   // ***********************************
   // file address resolution for byte-oriented operands
   function automatic logic [11:0] resolve_addr(input logic [7:0] f, input logic a,
                                                input logic ext, input logic [3:0] bank,
                                                input logic [11:0] ptr);
      logic [11:0] addr;
      addr = {ACCESS_LOW, f};
      if (a)
         addr = {bank, f};
      else if (ext && (f <= INDEX_LIMIT))
         addr = ptr + {4'h0, f};
      else if (f >= ACCESS_SPLIT)
         addr = {ACCESS_HIGH, f};
      return addr;
   endfunction

   function automatic alu_op_e decode_op(input logic [5:0] opc);
      case (opc)
         OPC_INC_SNZ: decode_op = OP_INC;
         OPC_SWAP:    decode_op = OP_SWAP;
         OPC_SUB_BRW: decode_op = OP_SUB;
         default:     decode_op = OP_NONE;
      endcase
   endfunction

   // ***********************************
   // state
   // ***********************************
   state_e                state, next_state;
   alu_op_e               op, next_op, dec_op;
   logic                  dest, next_dest;
   logic                  two_word, next_two_word;
   logic                  next_busy, next_file_we, next_wreg_we, next_status_we, next_flush;
   logic [11:0]           next_file_addr;
   logic [7:0]            next_file_wdata, next_wreg_wdata;
   logic [STATUS_W-1:0]   next_status;
   logic [PC_W-1:0]       stack_mem [DEPTH];
   logic [PC_W-1:0]       next_top;
   logic [4:0]            next_ptr;
   logic                  do_push, do_pop;
   logic [7:0]            alu_result;
   logic [STATUS_W-1:0]   alu_flags;
   logic                  alu_nonzero;

   byte_alu u_alu
   (
      .i_op      (op),
      .i_fdata   (i_file_rdata),
      .i_wreg    (i_wreg),
      .i_carry   (i_status[ST_C]),
      .o_result  (alu_result),
      .o_flags   (alu_flags),
      .o_nonzero (alu_nonzero)
   );

   // ***********************************
   // sequencer and result routing
   // ***********************************
   // stack ops finish in the taking cycle, so they never raise busy
   always_comb
   begin
      dec_op          = decode_op(i_instr[OPC_MSB:OPC_LSB]);
      next_state      = state;
      next_op         = op;
      next_dest       = dest;
      next_two_word   = two_word;
      next_busy       = o_busy;
      next_file_addr  = o_file_addr;
      next_file_wdata = o_file_wdata;
      next_wreg_wdata = o_wreg_wdata;
      next_status     = o_status;
      next_file_we    = 1'b0;
      next_wreg_we    = 1'b0;
      next_status_we  = 1'b0;
      next_flush      = 1'b0;
      do_push         = 1'b0;
      do_pop          = 1'b0;
      case (state)
         ST_IDLE:
         begin
            if (i_instr_valid)
            begin
               if (i_instr == INSTR_PUSH)
                  do_push = 1'b1;
               else if (i_instr == INSTR_POP)
                  do_pop = 1'b1;
               else if (dec_op != OP_NONE)
               begin
                  next_state     = ST_EXEC;
                  next_op        = dec_op;
                  next_dest      = i_instr[DEST_BIT];
                  next_busy      = 1'b1;
                  next_file_addr = resolve_addr(i_instr[7:0], i_instr[ACCESS_BIT], i_ext_en,
                                                i_bank_select_register, i_index_ptr);
               end
            end
         end
         ST_EXEC:
         begin
            if (dest)
            begin
               next_file_we    = 1'b1;
               next_file_wdata = alu_result;
            end
            else
            begin
               next_wreg_we    = 1'b1;
               next_wreg_wdata = alu_result;
            end
            // only subtract touches flags; increment and swap leave them
            if (op == OP_SUB)
            begin
               next_status_we = 1'b1;
               next_status    = alu_flags;
            end
            next_two_word = i_next_two_word;
            if ((op == OP_INC) && alu_nonzero)
            begin
               next_state = ST_SKIP1;
               next_flush = 1'b1;
            end
            else
            begin
               next_state = ST_IDLE;
               next_busy  = 1'b0;
            end
         end
         ST_SKIP1:
         begin
            if (two_word)
            begin
               next_state = ST_SKIP2;
               next_flush = 1'b1;
            end
            else
            begin
               next_state = ST_IDLE;
               next_busy  = 1'b0;
            end
         end
         ST_SKIP2:
         begin
            next_state = ST_IDLE;
            next_busy  = 1'b0;
         end
         default:
         begin
            next_state = ST_IDLE;
            next_busy  = 1'b0;
         end
      endcase
   end

   // ***********************************
   // return stack
   // ***********************************
   // top held apart from the array so it is always a flop output;
   // overflow drops the new entry, underflow yields zero
   always_comb
   begin
      next_top = o_return_stack_top;
      next_ptr = o_stack_ptr;
      if (do_push && (o_stack_ptr < 5'(DEPTH)))
      begin
         next_top = PC_W'(i_pc + PC_STEP);
         next_ptr = o_stack_ptr + 5'h01;
      end
      else if (do_pop && (o_stack_ptr != 5'h00))
      begin
         next_top = (o_stack_ptr > 5'h01) ? stack_mem[o_stack_ptr - 5'h02] : '0;
         next_ptr = o_stack_ptr - 5'h01;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (do_push && (o_stack_ptr != 5'h00) && (o_stack_ptr < 5'(DEPTH)))
         stack_mem[o_stack_ptr - 5'h01] <= o_return_stack_top;
   end

   // ***********************************
   // registers
   // ***********************************
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         state              <= ST_IDLE;
         op                 <= OP_NONE;
         dest               <= 1'b0;
         two_word           <= 1'b0;
         o_busy             <= 1'b0;
         o_file_addr        <= '0;
         o_file_we          <= 1'b0;
         o_file_wdata       <= '0;
         o_wreg_we          <= 1'b0;
         o_wreg_wdata       <= '0;
         o_status_we        <= 1'b0;
         o_status           <= '0;
         o_flush            <= 1'b0;
         o_return_stack_top <= '0;
         o_stack_ptr        <= '0;
      end
      else
      begin
         state              <= next_state;
         op                 <= next_op;
         dest               <= next_dest;
         two_word           <= next_two_word;
         o_busy             <= next_busy;
         o_file_addr        <= next_file_addr;
         o_file_we          <= next_file_we;
         o_file_wdata       <= next_file_wdata;
         o_wreg_we          <= next_wreg_we;
         o_wreg_wdata       <= next_wreg_wdata;
         o_status_we        <= next_status_we;
         o_status           <= next_status;
         o_flush            <= next_flush;
         o_return_stack_top <= next_top;
         o_stack_ptr        <= next_ptr;
      end
   end

endmodule
`default_nettype wire

/* verification/exec_slice_assertions.sv */
// concurrent checks on the execution slice ports
// assumes one clock domain and a synchronous active high reset
`timescale 1ns/1ps
`default_nettype none
module exec_slice_checker
   import exec_pkg::*;
#(
   parameter int PC_W  = 21,
   parameter int DEPTH = STACK_DEPTH
)
(
   input wire logic            i_clk,
   input wire logic            i_srst,
   input wire logic            i_instr_valid,
   input wire logic [15:0]     i_instr,
   input wire logic [PC_W-1:0] i_pc,
   input wire logic            o_busy,
   input wire logic            o_file_we,
   input wire logic            o_wreg_we,
   input wire logic            o_status_we,
   input wire logic            o_flush,
   input wire logic [PC_W-1:0] o_return_stack_top,
   input wire logic [4:0]      o_stack_ptr
);
   // ***********************************
   // decode helpers
   // ***********************************
   logic       take;
   logic       byte_op;
   logic       stk_op;
   logic [5:0] op_q;
   // acceptance mirrors the hand-over contract: valid while not busy
   assign take    = i_instr_valid && !o_busy;
   assign byte_op = (i_instr[OPC_MSB:OPC_LSB] == OPC_INC_SNZ)
                 || (i_instr[OPC_MSB:OPC_LSB] == OPC_SWAP)
                 || (i_instr[OPC_MSB:OPC_LSB] == OPC_SUB_BRW);
   assign stk_op  = (i_instr == INSTR_PUSH) || (i_instr == INSTR_POP);
   // last accepted byte opcode, to judge later pulses
   always_ff @(posedge i_clk)
      if (take && byte_op)
         op_q <= i_instr[OPC_MSB:OPC_LSB];

   default clocking @(posedge i_clk); endclocking
   default disable iff (i_srst);

   // ***********************************
   // properties
   // ***********************************
   a_byte_busy_write: assert property (take && byte_op |=> o_busy ##1 (o_file_we != o_wreg_we))
      else $error("byte op missing busy or single write");
   a_dest_file_write: assert property (take && byte_op && i_instr[DEST_BIT] |=> ##1 o_file_we)
      else $error("destination one did not write file");
   a_status_sub_only: assert property (o_status_we |-> op_q == OPC_SUB_BRW)
      else $error("status written by a non-subtract op");
   a_flush_inc_only: assert property (o_flush |-> o_busy && op_q == OPC_INC_SNZ)
      else $error("flush outside an increment skip");
   a_flush_two_max: assert property (o_flush ##1 o_flush |=> !o_flush)
      else $error("more than two flush cycles");
   a_file_we_pulse: assert property (o_file_we |=> !o_file_we)
      else $error("file write longer than one cycle");
   a_push_top_pc: assert property (take && i_instr == INSTR_PUSH && o_stack_ptr < DEPTH
      |=> o_return_stack_top == $past(i_pc) + PC_W'(PC_STEP))
      else $error("push top not pc plus two");
   a_push_ptr_up: assert property (take && i_instr == INSTR_PUSH && o_stack_ptr < DEPTH
      |=> o_stack_ptr == $past(o_stack_ptr) + 5'h01)
      else $error("push did not deepen stack");
   a_pop_ptr_down: assert property (take && i_instr == INSTR_POP && o_stack_ptr != 5'h00
      |=> o_stack_ptr == $past(o_stack_ptr) - 5'h01)
      else $error("pop did not shrink stack");
   a_stack_one_cycle: assert property (take && stk_op |=> !o_busy && !o_status_we)
      else $error("stack op stalled or touched flags");
endmodule
bind exec_slice exec_slice_checker #(.PC_W(PC_W), .DEPTH(DEPTH)) u_checker (.*);
`default_nettype wire

/* verification/cpu_increment_swap_subtract_stack_ops_test.sv */
// self-checking bench for the execution slice
// assumes the slice answers per its hand-over contract; file reads held steady
`timescale 1ns/1ps
`default_nettype none
module cpu_increment_swap_subtract_stack_ops_test;
   import exec_pkg::*;
   logic                i_clk = 1'b0, i_srst = 1'b1, i_instr_valid = 1'b0;
   logic                i_ext_en = 1'b0, i_next_two_word = 1'b0;
   logic [15:0]         i_instr = '0;
   logic [20:0]         i_pc = '0;
   logic [7:0]          i_wreg = '0, i_file_rdata = '0;
   logic [3:0]          i_bank_select_register = '0;
   logic [11:0]         i_index_ptr = '0;
   logic [STATUS_W-1:0] i_status = '0;
   logic                o_busy, o_file_we, o_wreg_we, o_status_we, o_flush;
   logic [11:0]         o_file_addr;
   logic [7:0]          o_file_wdata, o_wreg_wdata;
   logic [STATUS_W-1:0] o_status;
   logic [20:0]         o_return_stack_top;
   logic [4:0]          o_stack_ptr;
   int                  bad_count = 0, n_checks = 0, cyc = 0;

   exec_slice #(.PC_W(21), .DEPTH(31)) dut (.*);

   // ***********************************
   // clock, watchdog, helpers
   // ***********************************
   always #12.5 i_clk = ~i_clk;
   // a hung handshake must still reach the verdict
   always @(posedge i_clk)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         bad_count++;
         summarize();
      end
   end

   task summarize();
      if (bad_count == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // one byte op from take to idle; flush cycles counted over c2..c4
   task run_byte(input logic [15:0] ins, input logic [7:0] rd, input logic two,
                 input logic [11:0] ea, input logic [7:0] ed, input int nfl);
      int f;
      f = 0;
      i_instr = ins;
      i_file_rdata = rd;
      i_next_two_word = two;
      i_instr_valid = 1'b1;
      @(negedge i_clk);
      i_instr_valid = 1'b0;
      chk("busy", 1, o_busy);
      chk("file_addr", ea, o_file_addr);
      @(negedge i_clk);
      chk("file_we", ins[DEST_BIT], o_file_we);
      chk("wreg_we", !ins[DEST_BIT], o_wreg_we);
      chk("result", ed, ins[DEST_BIT] ? o_file_wdata : o_wreg_wdata);
      chk("status_we", ins[OPC_MSB:OPC_LSB] == OPC_SUB_BRW, o_status_we);
      repeat (3)
      begin
         f += o_flush;
         @(negedge i_clk);
      end
      chk("flush_count", nfl, f);
      chk("idle", 0, o_busy);
   endtask

   // ***********************************
   // scenarios
   // ***********************************
   task t_inc_skip();
      i_status = 5'h1F;
      i_bank_select_register = 4'hA;
      run_byte({OPC_INC_SNZ, 2'b11, 8'h34}, 8'h41, 1'b1, 12'hA34, 8'h42, 2);
      run_byte({OPC_INC_SNZ, 2'b11, 8'h34}, 8'h7F, 1'b0, 12'hA34, 8'h80, 1);
      run_byte({OPC_INC_SNZ, 2'b00, 8'hC5}, 8'hFF, 1'b1, 12'hFC5, 8'h00, 0);
   endtask

   task t_swap();
      i_ext_en = 1'b1;
      i_index_ptr = 12'h300;
      run_byte({OPC_SWAP, 2'b10, 8'h5F}, 8'h53, 1'b0, 12'h35F, 8'h35, 0);
      run_byte({OPC_SWAP, 2'b00, 8'h60}, 8'hA7, 1'b0, 12'h060, 8'h7A, 0);
      i_ext_en = 1'b0;
   endtask

   task t_sub();
      logic [7:0] fv[4];
      logic [7:0] wv[4];
      logic       cv[4];
      logic [7:0] rv[4];
      logic [4:0] sv[4];
      fv = '{8'h19, 8'h1B, 8'h03, 8'h80};
      wv = '{8'h0D, 8'h1A, 8'h0E, 8'h01};
      cv = '{1'b1, 1'b0, 1'b1, 1'b1};
      // results and N OV Z DC C worked by hand; last pair overflows signed range
      rv = '{8'h0C, 8'h00, 8'hF5, 8'h7F};
      sv = '{5'h01, 5'h07, 5'h10, 5'h09};
      for (int k = 0; k < 4; k++)
      begin
         i_wreg = wv[k];
         i_status = {4'h0, cv[k]};
         run_byte({OPC_SUB_BRW, k[0], 1'b0, 8'h25}, fv[k], 1'b0, 12'h025, rv[k], 0);
         chk("status", sv[k], o_status);
      end
   endtask

   // back-to-back stack ops, valid held high between them
   task stack_op(input logic [15:0] ins, input logic [20:0] pc,
                 input logic [20:0] et, input logic [4:0] ep);
      i_instr = ins;
      i_pc = pc;
      i_instr_valid = 1'b1;
      @(negedge i_clk);
      chk("stack_top", et, o_return_stack_top);
      chk("stack_ptr", ep, o_stack_ptr);
      chk("stack_busy", 0, o_busy);
   endtask

   task t_stack();
      stack_op(INSTR_PUSH, 21'h000124, 21'h000126, 5'h01);
      stack_op(INSTR_PUSH, 21'h003000, 21'h003002, 5'h02);
      stack_op(INSTR_POP, 21'h000000, 21'h000126, 5'h01);
      stack_op(INSTR_POP, 21'h000000, 21'h000000, 5'h00);
      i_instr_valid = 1'b0;
      @(negedge i_clk);
   endtask

   // reset in mid-run must empty the stack and idle the sequencer
   task t_reset();
      stack_op(INSTR_PUSH, 21'h000200, 21'h000202, 5'h01);
      i_instr_valid = 1'b0;
      i_srst = 1'b1;
      @(negedge i_clk);
      chk("rst_ptr", 0, o_stack_ptr);
      chk("rst_top", 0, o_return_stack_top);
      chk("rst_busy", 0, o_busy);
      i_srst = 1'b0;
      @(negedge i_clk);
   endtask

   // ***********************************
   // main sequence
   // ***********************************
   initial
   begin
      repeat (12) @(negedge i_clk);
      i_srst = 1'b0;
      @(negedge i_clk);
      t_inc_skip();
      t_swap();
      t_sub();
      t_stack();
      t_reset();
      summarize();
   end
endmodule
`default_nettype wire
